// ---- include/mce_consts.svh ----
// Constants for the miscellaneous control instruction executor
`ifndef MCE_CONSTS_SVH
`define MCE_CONSTS_SVH
// Fixed opcodes
`define MCE_OP_HALT 16'h0000
`define MCE_OP_WAIT 16'h0001
`define MCE_OP_BUS_RESET 16'h0005
// Opcode fields, bits 15:6 of the previous-space moves
`define MCE_OP_MOVE_FROM_PREV_INSTR_SPACE 10'h035
`define MCE_OP_MOVE_TO_PREV_INSTR_SPACE 10'h036
`define MCE_OP_MOVE_FROM_PREV_DATA_SPACE 10'h235
`define MCE_OP_MOVE_TO_PREV_DATA_SPACE 10'h236
// Condition code operators, bits 15:5
`define MCE_OP_CCOP 11'h005
`define MCE_CCOP_SENSE_BIT 4
// Status word fields
`define MCE_PSW_CUR_HI 15
`define MCE_PSW_CUR_LO 14
`define MCE_PSW_PRV_HI 13
`define MCE_PSW_PRV_LO 12
`define MCE_MODE_KERNEL 2'h0
// Stack step in bytes
`define MCE_STACK_STEP 16'h0002
// Bus initialize time
`define MCE_CLK_MHZ 100
`define MCE_INIT_TIME_MS 10
`define MCE_INIT_CYCLES (`MCE_INIT_TIME_MS * 1000 * `MCE_CLK_MHZ)
`define MCE_INIT_CNT_W 20
// Reset values
`define MCE_WORD_RST 16'h0000
`define MCE_CC_RST 4'h0
`endif

// ---- include/mce_pkg.sv ----
// Types for the miscellaneous control instruction executor
`default_nettype none
package mce_pkg;
  // Pending trap conditions, highest priority first
  typedef struct packed {
    logic parity;
    logic mmu;
    logic yellow;
    logic pwr;
    logic fpu;
    logic pir;
    logic br;
    logic trace;
  } mce_trap_vec_t;

  // One bus cycle request
  typedef struct packed {
    logic wr;
    logic [1:0] mode;
    logic ispace;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mce_bus_req_t;

  // Kind of trap sequence under way
  typedef enum logic [2:0] {
    MCE_TK_INSTR = 3'h0,
    MCE_TK_TRACE = 3'h1,
    MCE_TK_STKOVF = 3'h2,
    MCE_TK_BUSERR = 3'h3,
    MCE_TK_OTHER = 3'h4
  } mce_tkind_t;

  typedef enum logic [2:0] {
    MCE_ST_IDLE = 3'h0,
    MCE_ST_MV_RD = 3'h1,
    MCE_ST_MV_WR = 3'h3,
    MCE_ST_WAIT = 3'h2,
    MCE_ST_HALT = 3'h6,
    MCE_ST_INIT = 3'h7,
    MCE_ST_TSEQ = 3'h5
  } mce_state_t;
endpackage
`default_nettype wire

// ---- hw/mce_trap_prio.sv ----
// Fixed priority selector over pending trap conditions
`default_nettype none
module mce_trap_prio
  import mce_pkg::*;
(
  // Pending conditions
  input wire mce_trap_vec_t i_pend,
  // Selection
  output logic o_any,
  output mce_trap_vec_t o_sel
);
  logic [7:0] pv;
  logic [7:0] sel;

  assign pv = i_pend;

  always_comb
  begin
    sel = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      if (pv[i] && sel == 8'h00)
      begin
        sel[i] = 1'b1;
      end
    end
  end

  assign o_any = |pv;
  assign o_sel = sel;
endmodule
`default_nettype wire

// ---- hw/mce_misc_exec.sv ----
// Executor for halt, wait, bus reset, previous-space moves, cc ops
`include "mce_consts.svh"
`default_nettype none
module mce_misc_exec
  import mce_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = `MCE_INIT_CYCLES
)
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Instruction issue
  input wire logic I_INSTR_VALID,
  input wire logic [15:0] I_INSTR,
  input wire logic [15:0] I_EA,
  output logic O_INSTR_READY,
  output logic O_DONE,
  // Processor state
  input wire logic [15:0] I_PSW,
  input wire logic [15:0] I_SP,
  input wire logic [15:0] I_R0,
  input wire logic [15:0] I_PC,
  output logic O_CC_WE,
  output logic [3:0] O_CC,
  output logic O_SP_WE,
  output logic [15:0] O_SP,
  // System bus
  output logic O_BUS_REQ,
  output mce_bus_req_t O_BUS,
  input wire logic I_BUS_ACK,
  input wire logic [15:0] I_BUS_RDATA,
  input wire logic I_BUS_ERR,
  output logic O_BUS_INIT,
  // Traps
  input wire mce_trap_vec_t I_TRAP_PEND,
  output logic O_TRAP_TAKE,
  output mce_trap_vec_t O_TRAP_SEL,
  input wire logic I_TSEQ_START,
  input wire mce_tkind_t I_TSEQ_KIND,
  input wire logic I_TSEQ_DONE,
  input wire logic I_STK_OVF,
  output logic O_STKOVF_TRAP,
  output logic O_ILL_HALT_TRAP,
  // Console
  input wire logic I_CONSOLE_CONT,
  output logic O_HALTED,
  output logic O_CONSOLE_GRANT,
  output logic [15:0] O_CONSOLE_DATA,
  output logic [15:0] O_CONSOLE_ADDR,
  output logic O_WAITING
);
  mce_state_t state_r;
  mce_state_t state_nxt;
  mce_tkind_t tkind_r;
  logic [1:0] cont_sync_r;
  logic cont_prev_r;
  logic cont_rise;
  logic trap_any;
  mce_trap_vec_t trap_sel;
  logic is_halt;
  logic is_wait;
  logic is_rst;
  logic is_ccop;
  logic is_mv;
  logic mv_to_r;
  logic mv_isp_r;
  logic [15:0] ea_r;
  logic [15:0] word_r;
  logic [`MCE_INIT_CNT_W-1:0] init_cnt_r;
  logic init_last;
  logic defer_ovf_r;
  logic halt_on_err;
  logic wait_exit;
  logic take;
  logic accept;
  logic kernel;
  logic done_nxt;

  function automatic logic [1:0] cur_mode(input logic [15:0] psw);
    cur_mode = psw[`MCE_PSW_CUR_HI:`MCE_PSW_CUR_LO];
  endfunction

  function automatic logic [1:0] prv_mode(input logic [15:0] psw);
    prv_mode = psw[`MCE_PSW_PRV_HI:`MCE_PSW_PRV_LO];
  endfunction

  function automatic logic [3:0] mv_flags(input logic [15:0] w,
                                          input logic [3:0] cc);
    mv_flags = {w[15], (w == `MCE_WORD_RST), 1'b0, cc[0]};
  endfunction

  mce_trap_prio u_prio (
    .i_pend(I_TRAP_PEND),
    .o_any(trap_any),
    .o_sel(trap_sel)
  );

  // Console continue synchroniser
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      cont_sync_r <= 2'h0;
      cont_prev_r <= 1'b0;
    end
    else
    begin
      cont_sync_r <= {cont_sync_r[0], I_CONSOLE_CONT};
      cont_prev_r <= cont_sync_r[1];
    end
  end

  assign cont_rise = cont_sync_r[1] && !cont_prev_r;

  // Opcode decode
  assign is_halt = (I_INSTR == `MCE_OP_HALT);
  assign is_wait = (I_INSTR == `MCE_OP_WAIT);
  assign is_rst = (I_INSTR == `MCE_OP_BUS_RESET);
  assign is_ccop = (I_INSTR[15:5] == `MCE_OP_CCOP);
  assign is_mv = (I_INSTR[15:6] == `MCE_OP_MOVE_FROM_PREV_INSTR_SPACE) ||
                 (I_INSTR[15:6] == `MCE_OP_MOVE_TO_PREV_INSTR_SPACE) ||
                 (I_INSTR[15:6] == `MCE_OP_MOVE_FROM_PREV_DATA_SPACE) ||
                 (I_INSTR[15:6] == `MCE_OP_MOVE_TO_PREV_DATA_SPACE);
  assign kernel = (cur_mode(I_PSW) == `MCE_MODE_KERNEL);

  assign take = (state_r == MCE_ST_IDLE) && trap_any;
  assign O_INSTR_READY = (state_r == MCE_ST_IDLE) && !trap_any;
  assign accept = O_INSTR_READY && I_INSTR_VALID;

  assign wait_exit = I_TRAP_PEND.br || I_TRAP_PEND.pir ||
                     I_TRAP_PEND.fpu || I_TRAP_PEND.pwr ||
                     I_TRAP_PEND.parity;

  assign halt_on_err = (tkind_r == MCE_TK_INSTR) ||
                       (tkind_r == MCE_TK_TRACE) ||
                       (tkind_r == MCE_TK_STKOVF) ||
                       (tkind_r == MCE_TK_BUSERR);

  assign init_last = (init_cnt_r ==
                      `MCE_INIT_CNT_W'(INIT_CYCLES - 1));

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      MCE_ST_IDLE:
      begin
        if (I_TSEQ_START || take)
        begin
          state_nxt = MCE_ST_TSEQ;
        end
        else if (accept)
        begin
          if (is_halt && kernel)
          begin
            state_nxt = MCE_ST_HALT;
          end
          else if (is_wait)
          begin
            state_nxt = MCE_ST_WAIT;
          end
          else if (is_rst)
          begin
            state_nxt = MCE_ST_INIT;
          end
          else if (is_mv)
          begin
            state_nxt = MCE_ST_MV_RD;
          end
        end
      end
      MCE_ST_MV_RD:
      begin
        if (I_BUS_ERR)
        begin
          state_nxt = MCE_ST_IDLE;
        end
        else if (I_BUS_ACK)
        begin
          state_nxt = MCE_ST_MV_WR;
        end
      end
      MCE_ST_MV_WR:
      begin
        if (I_BUS_ERR || I_BUS_ACK)
        begin
          state_nxt = MCE_ST_IDLE;
        end
      end
      MCE_ST_WAIT:
      begin
        if (wait_exit)
        begin
          state_nxt = MCE_ST_IDLE;
        end
      end
      MCE_ST_HALT:
      begin
        if (cont_rise)
        begin
          state_nxt = MCE_ST_IDLE;
        end
      end
      MCE_ST_INIT:
      begin
        if (init_last)
        begin
          state_nxt = MCE_ST_IDLE;
        end
      end
      MCE_ST_TSEQ:
      begin
        if (I_BUS_ERR && halt_on_err)
        begin
          state_nxt = MCE_ST_HALT;
        end
        else if (I_TSEQ_DONE)
        begin
          state_nxt = MCE_ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = MCE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      state_r <= MCE_ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Trap take and sequence kind
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_TRAP_TAKE <= 1'b0;
      O_TRAP_SEL <= '0;
      tkind_r <= MCE_TK_OTHER;
    end
    else
    begin
      O_TRAP_TAKE <= 1'b0;
      if (state_r == MCE_ST_IDLE && I_TSEQ_START)
      begin
        tkind_r <= I_TSEQ_KIND;
      end
      else if (take)
      begin
        O_TRAP_TAKE <= 1'b1;
        O_TRAP_SEL <= trap_sel;
        if (trap_sel.yellow)
        begin
          tkind_r <= MCE_TK_STKOVF;
        end
        else if (trap_sel.trace)
        begin
          tkind_r <= MCE_TK_TRACE;
        end
        else
        begin
          tkind_r <= MCE_TK_OTHER;
        end
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      defer_ovf_r <= 1'b0;
      O_STKOVF_TRAP <= 1'b0;
    end
    else
    begin
      O_STKOVF_TRAP <= 1'b0;
      if (state_r == MCE_ST_TSEQ &&
          (tkind_r == MCE_TK_BUSERR || tkind_r == MCE_TK_INSTR ||
           tkind_r == MCE_TK_TRACE))
      begin
        if (I_TSEQ_DONE)
        begin
          O_STKOVF_TRAP <= defer_ovf_r || I_STK_OVF;
          defer_ovf_r <= 1'b0;
        end
        else if (I_STK_OVF)
        begin
          defer_ovf_r <= 1'b1;
        end
      end
      else
      begin
        defer_ovf_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_ILL_HALT_TRAP <= 1'b0;
    end
    else
    begin
      O_ILL_HALT_TRAP <= accept && is_halt && !kernel;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_CONSOLE_DATA <= `MCE_WORD_RST;
      O_CONSOLE_ADDR <= `MCE_WORD_RST;
    end
    else if (state_nxt == MCE_ST_HALT && state_r != MCE_ST_HALT)
    begin
      O_CONSOLE_DATA <= I_R0;
      O_CONSOLE_ADDR <= I_PC;
    end
  end

  assign O_HALTED = (state_r == MCE_ST_HALT);
  assign O_CONSOLE_GRANT = (state_r == MCE_ST_HALT);
  assign O_WAITING = (state_r == MCE_ST_WAIT);

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      init_cnt_r <= '0;
    end
    else if (state_r == MCE_ST_INIT)
    begin
      init_cnt_r <= init_cnt_r + `MCE_INIT_CNT_W'(1);
    end
    else
    begin
      init_cnt_r <= '0;
    end
  end

  assign O_BUS_INIT = (state_r == MCE_ST_INIT);

  // Move operands
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      mv_to_r <= 1'b0;
      mv_isp_r <= 1'b0;
      ea_r <= `MCE_WORD_RST;
      word_r <= `MCE_WORD_RST;
    end
    else
    begin
      if (accept && is_mv)
      begin
        mv_to_r <= I_INSTR[7];
        mv_isp_r <= !I_INSTR[15];
        ea_r <= I_EA;
      end
      if (state_r == MCE_ST_MV_RD && I_BUS_ACK)
      begin
        word_r <= I_BUS_RDATA;
      end
    end
  end

  assign O_BUS_REQ = (state_r == MCE_ST_MV_RD) ||
                     (state_r == MCE_ST_MV_WR);

  always_comb
  begin
    O_BUS = '0;
    if (state_r == MCE_ST_MV_RD)
    begin
      O_BUS.wr = 1'b0;
      if (mv_to_r)
      begin
        O_BUS.mode = cur_mode(I_PSW);
        O_BUS.addr = I_SP;
      end
      else
      begin
        O_BUS.mode = prv_mode(I_PSW);
        O_BUS.ispace = mv_isp_r;
        O_BUS.addr = ea_r;
      end
    end
    else if (state_r == MCE_ST_MV_WR)
    begin
      O_BUS.wr = 1'b1;
      O_BUS.wdata = word_r;
      if (mv_to_r)
      begin
        O_BUS.mode = prv_mode(I_PSW);
        O_BUS.ispace = mv_isp_r;
        O_BUS.addr = ea_r;
      end
      else
      begin
        O_BUS.mode = cur_mode(I_PSW);
        O_BUS.addr = I_SP - `MCE_STACK_STEP;
      end
    end
  end

  // Stack pointer and flag updates
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_SP_WE <= 1'b0;
      O_SP <= `MCE_WORD_RST;
      O_CC_WE <= 1'b0;
      O_CC <= `MCE_CC_RST;
    end
    else
    begin
      O_SP_WE <= 1'b0;
      O_CC_WE <= 1'b0;
      if (accept && is_ccop)
      begin
        O_CC_WE <= 1'b1;
        if (I_INSTR[`MCE_CCOP_SENSE_BIT])
        begin
          O_CC <= I_PSW[3:0] | I_INSTR[3:0];
        end
        else
        begin
          O_CC <= I_PSW[3:0] & ~I_INSTR[3:0];
        end
      end
      else if (state_r == MCE_ST_MV_RD && I_BUS_ACK && mv_to_r)
      begin
        O_SP_WE <= 1'b1;
        O_SP <= I_SP + `MCE_STACK_STEP;
      end
      else if (state_r == MCE_ST_MV_WR && I_BUS_ACK)
      begin
        O_CC_WE <= 1'b1;
        O_CC <= mv_flags(word_r, I_PSW[3:0]);
        if (!mv_to_r)
        begin
          O_SP_WE <= 1'b1;
          O_SP <= I_SP - `MCE_STACK_STEP;
        end
      end
    end
  end

  // Completion pulse
  always_comb
  begin
    done_nxt = 1'b0;
    if (accept && is_ccop)
    begin
      done_nxt = 1'b1;
    end
    else if (state_r != MCE_ST_IDLE && state_r != MCE_ST_TSEQ &&
             state_nxt == MCE_ST_IDLE)
    begin
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_DONE <= 1'b0;
    end
    else
    begin
      O_DONE <= done_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- tb/mce_misc_exec_properties.sv ----
// Checker of the misc control executor port behaviour
`default_nettype none
module mce_misc_exec_chk
  import mce_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = 8
)
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Instruction and state
  input wire logic I_INSTR_VALID,
  input wire logic [15:0] I_INSTR,
  input wire logic [15:0] I_PSW,
  input wire logic [15:0] I_R0,
  input wire logic [15:0] I_PC,
  input wire logic O_INSTR_READY,
  input wire logic O_CC_WE,
  input wire logic [3:0] O_CC,
  // Bus and traps
  input wire logic O_BUS_REQ,
  input wire logic O_BUS_INIT,
  input wire mce_trap_vec_t I_TRAP_PEND,
  input wire logic O_TRAP_TAKE,
  input wire mce_trap_vec_t O_TRAP_SEL,
  input wire logic O_ILL_HALT_TRAP,
  // Console and wait
  input wire logic O_HALTED,
  input wire logic [15:0] O_CONSOLE_DATA,
  input wire logic [15:0] O_CONSOLE_ADDR,
  input wire logic O_WAITING
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc;
  logic [31:0] init_cnt_r;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  assign acc = O_INSTR_READY & I_INSTR_VALID;
  function automatic logic [7:0] top1(input logic [7:0] v);
    top1 = 8'h00;
    for (int i = 0; i < 8; i++)
      if (v[i])
        top1 = 8'h01 << i;
  endfunction
  // Cycles of initialize held
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N || !O_BUS_INIT)
      init_cnt_r <= 32'h0;
    else
      init_cnt_r <= init_cnt_r + 32'h1;
  end
  chk_trap_prio: assert property (
    O_TRAP_TAKE |-> O_TRAP_SEL == top1($past(I_TRAP_PEND)))
    else $error("trap selection not highest pending");
  chk_ready_gate: assert property (
    O_INSTR_READY |-> I_TRAP_PEND == 8'h00 && !O_HALTED && !O_WAITING &&
    !O_BUS_REQ && !O_BUS_INIT)
    else $error("ready while trap pending");
  chk_cc_update: assert property (
    acc && I_INSTR[15:5] == 11'h005 |=> O_CC_WE && O_CC ==
    ($past(I_INSTR[4]) ? $past(I_PSW[3:0] | I_INSTR[3:0])
    : $past(I_PSW[3:0] & ~I_INSTR[3:0])))
    else $error("flag operator result wrong");
  chk_halt_show: assert property (
    acc && I_INSTR == 16'h0000 && I_PSW[15:14] == 2'h0 |=> O_HALTED &&
    !O_CC_WE && O_CONSOLE_DATA == $past(I_R0) &&
    O_CONSOLE_ADDR == $past(I_PC))
    else $error("halt entry or console display wrong");
  chk_halt_trap: assert property (
    acc && I_INSTR == 16'h0000 && I_PSW[15:14] != 2'h0 |=>
    O_ILL_HALT_TRAP && !O_HALTED)
    else $error("halt outside kernel not trapped");
  chk_halt_quiet: assert property (
    O_HALTED |-> !O_BUS_REQ && !O_BUS_INIT && !O_INSTR_READY)
    else $error("bus activity while halted");
  chk_wait_quiet: assert property (
    O_WAITING |-> !O_BUS_REQ && !O_INSTR_READY)
    else $error("bus request while waiting");
  chk_wait_exit: assert property (
    O_WAITING && (I_TRAP_PEND.fpu || I_TRAP_PEND.pwr ||
    I_TRAP_PEND.parity) |-> ##1 !O_WAITING)
    else $error("wait not ended by trap");
  chk_init_len: assert property (
    $fell(O_BUS_INIT) |-> init_cnt_r == INIT_CYCLES)
    else $error("initialize length wrong");
endmodule
bind mce_misc_exec mce_misc_exec_chk #(.INIT_CYCLES(INIT_CYCLES)) i_chk (
  .I_CLK, .I_RST_N, .I_INSTR_VALID, .I_INSTR, .I_PSW, .I_R0, .I_PC,
  .O_INSTR_READY, .O_CC_WE, .O_CC, .O_BUS_REQ, .O_BUS_INIT, .I_TRAP_PEND,
  .O_TRAP_TAKE, .O_TRAP_SEL, .O_ILL_HALT_TRAP, .O_HALTED, .O_CONSOLE_DATA,
  .O_CONSOLE_ADDR, .O_WAITING);
`default_nettype wire

// ---- tb/mce_bus_mem.sv ----
// Memory model answering the executor's bus cycles
`default_nettype none
module mce_bus_mem
  import mce_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Bus from executor
  input wire logic i_req,
  input wire mce_bus_req_t i_bus,
  input wire logic [3:0] i_delay,
  // Answer
  output logic o_ack,
  output logic [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [1024];
  logic [3:0] cnt_r;
  logic [9:0] idx;
  assign idx = {i_bus.mode, i_bus.ispace, i_bus.addr[7:1]};
  always @(posedge i_clk)
  begin
    o_ack <= 1'b0;
    o_rdata <= i_rst_n ? ~o_rdata : 16'hA5A5;
    if (!i_rst_n || o_ack || !i_req)
      cnt_r <= 4'h0;
    else if (cnt_r != i_delay)
      cnt_r <= cnt_r + 4'h1;
    else
    begin
      o_ack <= 1'b1;
      if (i_bus.wr)
        mem[idx] <= i_bus.wdata;
      else
        o_rdata <= mem[idx];
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the misc control executor
`default_nettype none
module testbench
  import mce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic iv = 1'b0;
  logic [15:0] ins = 16'h0000;
  logic [15:0] ea = 16'h0000;
  logic [15:0] psw = 16'h0000;
  logic [15:0] sp = 16'h0040;
  logic [15:0] r0 = 16'h0000;
  logic [15:0] pc = 16'h0000;
  logic tberr = 1'b0;
  logic tstart = 1'b0;
  logic tdone = 1'b0;
  logic stk = 1'b0;
  logic cont = 1'b0;
  logic [3:0] dly = 4'h0;
  mce_tkind_t tkind = MCE_TK_INSTR;
  mce_trap_vec_t pend = 8'h00;
  logic rdy, done, ccwe, spwe, breq, ack, binit, take;
  logic ovf, ill, halted, grant, waiting;
  logic [3:0] cc;
  logic [15:0] spo, rdata, cdata, caddr;
  mce_bus_req_t bus;
  mce_trap_vec_t sel;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] ccop [12] = '{16'h00A0, 16'h00A3, 16'h00A1, 16'h00A2,
    16'h00A4, 16'h00A8, 16'h00B1, 16'h00B2, 16'h00B4, 16'h00B8,
    16'h00AF, 16'h00BF};
  logic [15:0] mvop [4] = '{16'h0D80, 16'h8D80, 16'h0D40, 16'h8D40};
  logic [15:0] wd [4] = '{16'h8001, 16'h0000, 16'h1234, 16'h8000};
  mce_misc_exec #(.INIT_CYCLES(8)) i_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_INSTR_VALID(iv), .I_INSTR(ins),
    .I_EA(ea), .O_INSTR_READY(rdy), .O_DONE(done), .I_PSW(psw),
    .I_SP(sp), .I_R0(r0), .I_PC(pc), .O_CC_WE(ccwe), .O_CC(cc),
    .O_SP_WE(spwe), .O_SP(spo), .O_BUS_REQ(breq), .O_BUS(bus),
    .I_BUS_ACK(ack), .I_BUS_RDATA(rdata), .I_BUS_ERR(tberr),
    .O_BUS_INIT(binit), .I_TRAP_PEND(pend), .O_TRAP_TAKE(take),
    .O_TRAP_SEL(sel), .I_TSEQ_START(tstart), .I_TSEQ_KIND(tkind),
    .I_TSEQ_DONE(tdone), .I_STK_OVF(stk), .O_STKOVF_TRAP(ovf),
    .O_ILL_HALT_TRAP(ill), .I_CONSOLE_CONT(cont), .O_HALTED(halted),
    .O_CONSOLE_GRANT(grant), .O_CONSOLE_DATA(cdata),
    .O_CONSOLE_ADDR(caddr), .O_WAITING(waiting));
  mce_bus_mem i_mem (
    .i_clk(clk), .i_rst_n(rst_n), .i_req(breq), .i_bus(bus),
    .i_delay(dly), .o_ack(ack), .o_rdata(rdata));
  always #5 clk = ~clk;
  // Stack pointer follows the executor
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (spwe === 1'b1)
      sp <= spo;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  function automatic logic [9:0] idx(logic [1:0] m, logic s, logic [15:0] a);
    idx = {m, s, a[7:1]};
  endfunction
  task automatic issue(input logic [15:0] op, a);
    @(negedge clk);
    while (rdy !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    iv <= 1'b1;
    ins <= op;
    ea <= a;
    @(posedge clk);
    iv <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_hi(input int s);
    int n;
    n = 0;
    while ((s == 0 ? done : take) !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk("wait_hi", 16'h0, 16'(n == 200));
  endtask
  task automatic end_seq();
    @(posedge clk);
    pend <= 8'h00;
    tdone <= 1'b1;
    @(posedge clk);
    tdone <= 1'b0;
  endtask
  task automatic resume();
    @(posedge clk);
    cont <= 1'b1;
    wait_hi(0);
    chk("resume", 16'h0, 16'({halted, binit})); // no init
    @(posedge clk);
    cont <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic tseq(input int k);
    @(posedge clk);
    tstart <= 1'b1;
    tkind <= mce_tkind_t'(k);
    @(posedge clk);
    tstart <= 1'b0;
  endtask
  initial
  begin
    int n;
    logic [3:0] e;
    logic to, isp;
    logic [15:0] s0, m;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ccop[i])
    begin
      psw <= 16'(i * 7 % 16);
      issue(ccop[i], 16'h0000);
      e = ccop[i][4] ? psw[3:0] | ccop[i][3:0] : psw[3:0] & ~ccop[i][3:0];
      chk("ccop", 16'({1'b1, e}), 16'({ccwe, cc})); // flags
    end
    psw <= 16'hD003;
    foreach (mvop[i])
    begin
      to = i < 2;
      isp = i % 2 == 0;
      s0 = sp;
      dly <= 4'(i * 2);
      if (to)
        i_mem.mem[idx(2'h3, 1'b0, s0)] = wd[i];
      else
        i_mem.mem[idx(2'h1, isp, 16'h0020)] = wd[i];
      issue(mvop[i], 16'h0020);
      wait_hi(0);
      e = {wd[i][15], wd[i] == 16'h0, 2'b01};
      chk("mvcc", 16'({1'b1, e}), 16'({ccwe, cc})); // move flags
      @(negedge clk);
      chk("mvsp", to ? s0 + 16'h2 : s0 - 16'h2, sp); // stack
      m = to ? i_mem.mem[idx(2'h1, isp, 16'h0020)]
        : i_mem.mem[idx(2'h3, 1'b0, s0 - 16'h2)];
      chk("mvmem", wd[i], m); // spaces
    end
    psw <= 16'h0000;
    r0 <= 16'h1234;
    pc <= 16'h0102;
    issue(16'h0000, 16'h0000);
    @(negedge clk);
    chk("halt", 16'h0003, 16'({halted, grant})); // halt entry
    chk("cdata", 16'h1234, cdata); // shown word
    chk("caddr", 16'h0102, caddr); // shown address
    resume();
    psw <= 16'hC000;
    issue(16'h0000, 16'h0000);
    chk("illhalt", 16'h0001, 16'({halted, ill})); // mode trap
    psw <= 16'h0000;
    issue(16'h0001, 16'h0000);
    @(negedge clk);
    chk("wait", 16'h0001, 16'({breq, waiting})); // idle bus
    @(posedge clk);
    pend <= 8'h08;
    wait_hi(1);
    chk("wexit", 16'h0008, 16'({waiting, sel})); // wait ends
    end_seq();
    issue(16'h0005, 16'h0000);
    n = 0;
    while (binit === 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    chk("init", 16'h0008, 16'(n)); // init length
    for (int k = 0; k < 8; k++)
    begin
      @(negedge clk);
      while (rdy !== 1'b1)
        @(negedge clk);
      @(posedge clk);
      pend <= 8'hFF >> k;
      wait_hi(1);
      chk("prio", 16'(8'h80 >> k), 16'(sel)); // order
      end_seq();
    end
    for (int k = 0; k < 5; k++)
    begin
      tseq(k);
      tberr <= 1'b1;
      @(posedge clk);
      tberr <= 1'b0;
      @(negedge clk);
      chk("errhalt", 16'(k < 4), 16'(halted)); // double fault
      if (k < 4)
        resume();
      else
        end_seq();
    end
    tseq(3);
    stk <= 1'b1;
    @(posedge clk);
    stk <= 1'b0;
    @(negedge clk);
    chk("ovfearly", 16'h0, 16'(ovf)); // deferred
    end_seq();
    @(negedge clk);
    chk("ovflate", 16'h1, 16'(ovf)); // taken after
    finish_test();
  end
endmodule
`default_nettype wire
